/* hw/uart_lmsc.v */
`timescale 1ns/1ns
`include "uart_lmsc_consts.vh"

// Function
// RULE1: Parity bit appended and checked when enabled.
// RULE2: Parity type bit selects odd or even.
// RULE3: Forced parity is inverse of type bit.
// RULE4: Break bit holds serial output low.
// RULE5: Divisor access bit maps divisor latches.
// RULE6: Terminal ready pin is inverse of bit.
// RULE7: Send request pin is inverse of bit.
// RULE8: Pin select muxes modem pins, loop ring.
// RULE9: Interrupt pin enable, loop second output.
// RULE10: Loopback bit enables internal local loopback.
// RULE11: Any character resumes stopped transmitter.
// RULE12: Infrared path, transmit rests low idle.
// RULE13: Prescaler divides baud clock by four.
// RULE14: Overrun interrupts at once, tags at head.
// RULE15: Data ready while any character held.
// RULE16: Overrun on full FIFO keeps FIFO data.
// RULE17: Error tags describe head character; framing.
// RULE18: Long low loads one break character.
// RULE19: Holding empty tracks empty transmit FIFO.
// RULE20: Transmitter empty when FIFO and shifter empty.
// RULE21: Error summary while any tagged byte.
// RULE22: Low field sets post-transmit send hold.
// RULE23: Send request asserted before data programmable.
// RULE24: High field holds pre-transmit delay.
// RULE25: Low field selects flow hysteresis characters.
// RULE26: Status read-only, tags advance on read.
module uart_lmsc (
	// Clock and reset
	input wire sys_clk,
	input wire srst,
	// Host register port
	input wire [2:0] addr,
	input wire wr_stb,
	input wire rd_stb,
	input wire [7:0] wdata,
	output reg [7:0] rdata,
	input wire [1:0] bus_mode,
	output reg int_o,
	output reg int_oe,
	// Serial line
	input wire rx_i,
	output reg tx_o,
	// Modem and loopback outputs
	output reg dtr_n,
	output reg rts_n,
	output reg modem_pin_sel,
	output reg loop_out_one_n,
	output reg loop_out_two_n,
	// Feature controls
	input wire feat_unlock,
	input wire half_duplex_en,
	input wire auto_rts_en,
	input wire prog_trig,
	input wire [7:0] rx_trigger,
	input wire sw_flow_en,
	input wire [7:0] xon_char,
	input wire [7:0] xoff_char,
	output reg tx_flow_stopped
);

localparam TS_IDLE = 4'b0001;
localparam TS_LEAD = 4'b0010;
localparam TS_SEND = 4'b0100;
localparam TS_TAIL = 4'b1000;
localparam RS_IDLE = 3'b001;
localparam RS_RECV = 3'b010;
localparam RS_BRKW = 3'b100;

// ==========================================
// Helpers
// ==========================================
function par_calc(input [7:0] d, input [7:0] lc);
	reg [7:0] m;
	begin
		m = d & (8'hFF >> (2'h3 - lc[1:0]));
		// RULE3: forced parity level.
		if (lc[`LCR_FORCE])
			par_calc = ~lc[`LCR_EVEN];
		// RULE2: even or odd parity.
		else if (lc[`LCR_EVEN])
			par_calc = ^m;
		else
			par_calc = ~^m;
	end
endfunction

function [8:0] hyst_of(input [3:0] c);
	begin
		if (c >= 4'hC)
			hyst_of = 9'h034;
		else
			hyst_of = {3'h0, c, 2'h0} + 9'h004;
	end
endfunction

// ==========================================
// Registers and baud generator
// ==========================================
reg [7:0] lcr_r, mcr_r, ier_r, shr_r, frac_r;
reg [15:0] div_r, bcnt_r;
reg [1:0] pre_r;
reg fifo_en_r, ovr_r, flow_off_r;
reg [3:0] tx_st_r, tx_tick_r, tx_bits_r, tx_dly_r;
reg [11:0] tx_sh_r, tx_frame;
reg [7:0] tx_mem [0:127];
reg [6:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
reg [7:0] tx_cnt_r, rx_cnt_r, err_cnt_r;
reg [2:0] rx_st_r;
reg [3:0] rx_tick_r, rx_bits_r;
reg [11:0] rx_sh_r;
reg [10:0] rx_mem [0:127];
reg [4:0] ir_hold_r;

wire dlab = lcr_r[`LCR_DLAB];
wire loop = mcr_r[`MCR_LOOP];
wire [1:0] wl = lcr_r[1:0];
wire pen = lcr_r[`LCR_PEN];
wire [7:0] len_mask = 8'hFF >> (2'h3 - wl);
wire [7:0] fifo_lim = fifo_en_r ? `FIFO_DEPTH : 8'h01;
wire [3:0] tx_nbits = 4'h7 + {2'h0, wl} + {3'h0, pen} + {3'h0, lcr_r[2]};
wire [3:0] rx_last = 4'h6 + {2'h0, wl} + {3'h0, pen};

// RULE13: optional divide by four ahead of the divisor.
wire pre_tick = ~mcr_r[`MCR_PRESC] | (pre_r == 2'h3);
wire [15:0] bcnt_inc = bcnt_r + 16'h0001;
wire tick = pre_tick & (bcnt_inc >= div_r);

// RULE5: divisor access bit steers the shared locations.
wire wr_data = wr_stb & (addr == `A_DATA) & ~dlab;
wire fcr_wr = wr_stb & (addr == `A_FCR) & ~dlab & wdata[`FCR_EN];
wire tx_rst = fcr_wr & wdata[`FCR_TXRST];
wire rx_rst = fcr_wr & wdata[`FCR_RXRST];
wire lsr_rd = rd_stb & (addr == `A_LSR);

// ==========================================
// Transmitter
// ==========================================
wire [7:0] tx_head = tx_mem[tx_rp_r];
wire tx_push = wr_data & (tx_cnt_r < fifo_lim);
wire tx_ready = (tx_cnt_r != 8'h00) & ~tx_flow_stopped;
wire tx_bit_done = tick & (tx_tick_r == 4'hF);
wire tx_line = (tx_st_r == TS_SEND) ? tx_sh_r[0] : 1'b1;
// RULE23: optional lead time before the first byte.
wire tx_load = ((tx_st_r == TS_IDLE) & tx_ready & (~half_duplex_en | (shr_r[7:4] == 4'h0)))
	| ((tx_st_r == TS_LEAD) & tx_bit_done & (tx_dly_r == 4'h1))
	| ((tx_st_r == TS_SEND) & tx_bit_done & (tx_bits_r == 4'h1) & tx_ready)
	| ((tx_st_r == TS_TAIL) & tx_ready);

always @* begin
	tx_frame = 12'hFFF;
	tx_frame[8:1] = tx_head | ~len_mask;
	tx_frame[0] = 1'b0;
	// RULE1: parity bit follows the data bits.
	if (pen)
		tx_frame[{2'h0, wl} + 4'h6] = par_calc(tx_head, lcr_r);
end

always @(posedge sys_clk) begin
	if (tx_push)
		tx_mem[tx_wp_r] <= wdata;
end

always @(posedge sys_clk) begin
	if (srst || tx_rst) begin
		tx_wp_r <= 7'h00;
		tx_rp_r <= 7'h00;
		tx_cnt_r <= 8'h00;
	end else begin
		if (tx_push)
			tx_wp_r <= tx_wp_r + 7'h01;
		if (tx_load)
			tx_rp_r <= tx_rp_r + 7'h01;
		tx_cnt_r <= tx_cnt_r + {7'h00, tx_push} - {7'h00, tx_load};
	end
end

always @(posedge sys_clk) begin
	if (srst) begin
		tx_st_r <= TS_IDLE;
		tx_tick_r <= 4'h0;
		tx_bits_r <= 4'h0;
		tx_dly_r <= 4'h0;
		tx_sh_r <= 12'hFFF;
	end else begin
		if (tick)
			tx_tick_r <= tx_tick_r + 4'h1;
		if (tx_load) begin
			tx_sh_r <= tx_frame;
			tx_bits_r <= tx_nbits;
			tx_tick_r <= 4'h0;
			tx_st_r <= TS_SEND;
		end else begin
			case (tx_st_r)
			TS_IDLE: begin
				// RULE24: lead time comes from the upper field.
				if (tx_ready) begin
					tx_st_r <= TS_LEAD;
					tx_dly_r <= shr_r[7:4];
					tx_tick_r <= 4'h0;
				end
			end
			TS_LEAD: begin
				if (tx_bit_done)
					tx_dly_r <= tx_dly_r - 4'h1;
			end
			TS_SEND: begin
				if (tx_bit_done) begin
					tx_sh_r <= {1'b1, tx_sh_r[11:1]};
					tx_bits_r <= tx_bits_r - 4'h1;
					// RULE22: hold time after the last byte.
					if (tx_bits_r == 4'h1) begin
						tx_dly_r <= shr_r[3:0];
						if (half_duplex_en && shr_r[3:0] != 4'h0)
							tx_st_r <= TS_TAIL;
						else
							tx_st_r <= TS_IDLE;
					end
				end
			end
			TS_TAIL: begin
				if (tx_bit_done) begin
					tx_dly_r <= tx_dly_r - 4'h1;
					if (tx_dly_r == 4'h1)
						tx_st_r <= TS_IDLE;
				end
			end
			default: begin
				tx_st_r <= TS_IDLE;
			end
			endcase
		end
	end
end

// ==========================================
// Receiver
// ==========================================
// RULE12: an infrared pulse stands for a zero bit.
wire ir_zero = (ir_hold_r != 5'h00);
// RULE10: in loopback the receiver hears the transmitter.
wire rx_raw = loop ? tx_line : (mcr_r[`MCR_IR] ? ~ir_zero : rx_i);
wire [11:0] rx_w = rx_sh_r | ({11'h000, rx_raw} << rx_bits_r);
wire [7:0] rx_data = rx_w[8:1] & len_mask;
wire rx_brk = (rx_w == 12'h000);
// RULE1: received parity compared with the expected bit.
wire rx_pe = pen & (rx_w[{2'h0, wl} + 4'h6] != par_calc(rx_data, lcr_r));
// RULE17: framing error when the stop bit reads low.
wire rx_fe = ~rx_raw;
wire rx_mid = tick & (rx_tick_r == 4'h7) & (rx_st_r == RS_RECV);
wire rx_done = rx_mid & (rx_bits_r == rx_last);
wire is_xon = sw_flow_en & (rx_data == xon_char) & ~rx_brk;
wire is_xoff = sw_flow_en & (rx_data == xoff_char) & ~rx_brk;
wire rx_full = (rx_cnt_r >= fifo_lim);
// RULE16: a full FIFO refuses the new character.
wire rx_push = rx_done & ~rx_full & ~is_xon & ~is_xoff;
wire ovr_ev = rx_done & rx_full & ~is_xon & ~is_xoff;
wire [2:0] rx_tags = rx_brk ? 3'h4 : {1'b0, rx_fe, rx_pe};
wire [10:0] rx_head = rx_mem[rx_rp_r];
wire rx_any = (rx_cnt_r != 8'h00);
wire rx_pop = rd_stb & (addr == `A_DATA) & ~dlab & rx_any;
wire head_err = rx_any & (rx_head[10:8] != 3'h0);
wire [8:0] rts_hi = {1'b0, rx_trigger} + hyst_of(shr_r[3:0]);
wire [8:0] rts_lo = {1'b0, rx_trigger} - hyst_of(shr_r[3:0]);

always @(posedge sys_clk) begin
	if (rx_push)
		rx_mem[rx_wp_r] <= {rx_tags, rx_data};
end

// RULE21: count of tagged bytes held in the FIFO.
always @(posedge sys_clk) begin
	if (srst || rx_rst) begin
		rx_wp_r <= 7'h00;
		rx_rp_r <= 7'h00;
		rx_cnt_r <= 8'h00;
		err_cnt_r <= 8'h00;
	end else begin
		if (rx_push)
			rx_wp_r <= rx_wp_r + 7'h01;
		// RULE26: reading the head advances the tags.
		if (rx_pop)
			rx_rp_r <= rx_rp_r + 7'h01;
		rx_cnt_r <= rx_cnt_r + {7'h00, rx_push} - {7'h00, rx_pop};
		err_cnt_r <= err_cnt_r + {7'h00, rx_push & (rx_tags != 3'h0)} - {7'h00, rx_pop & head_err};
	end
end

always @(posedge sys_clk) begin
	if (srst) begin
		rx_st_r <= RS_IDLE;
		rx_tick_r <= 4'h0;
		rx_bits_r <= 4'h0;
		rx_sh_r <= 12'h000;
		ir_hold_r <= 5'h00;
	end else begin
		if (rx_i)
			ir_hold_r <= `IR_HOLD;
		else if (tick && ir_zero)
			ir_hold_r <= ir_hold_r - 5'h01;
		case (rx_st_r)
		RS_IDLE: begin
			if (tick && !rx_raw) begin
				rx_st_r <= RS_RECV;
				rx_tick_r <= 4'h0;
				rx_bits_r <= 4'h0;
				rx_sh_r <= 12'h000;
			end
		end
		RS_RECV: begin
			if (tick)
				rx_tick_r <= rx_tick_r + 4'h1;
			if (rx_mid) begin
				if (rx_bits_r == 4'h0 && rx_raw)
					rx_st_r <= RS_IDLE;
				// RULE18: an all-low frame waits for the line to rise.
				else if (rx_done)
					rx_st_r <= rx_brk ? RS_BRKW : RS_IDLE;
				else begin
					rx_sh_r <= rx_w;
					rx_bits_r <= rx_bits_r + 4'h1;
				end
			end
		end
		RS_BRKW: begin
			if (rx_raw)
				rx_st_r <= RS_IDLE;
		end
		default: begin
			rx_st_r <= RS_IDLE;
		end
		endcase
	end
end

// ==========================================
// Host writes and line state
// ==========================================
always @(posedge sys_clk) begin
	if (srst) begin
		lcr_r <= `LCR_RST;
		mcr_r <= `MCR_RST;
		ier_r <= `IER_RST;
		shr_r <= `SHR_RST;
		frac_r <= `FRAC_RST;
		div_r <= `DIV_RST;
		fifo_en_r <= 1'b0;
		pre_r <= 2'h0;
		bcnt_r <= 16'h0000;
		ovr_r <= 1'b0;
		flow_off_r <= 1'b0;
		tx_flow_stopped <= 1'b0;
	end else begin
		pre_r <= pre_r + 2'h1;
		if (pre_tick)
			bcnt_r <= tick ? 16'h0000 : bcnt_inc;
		if (wr_stb) begin
			case (addr)
			`A_DATA: begin
				if (dlab)
					div_r[7:0] <= wdata;
			end
			`A_IER: begin
				if (dlab)
					div_r[15:8] <= wdata;
				else
					ier_r <= wdata;
			end
			`A_FCR: begin
				if (dlab)
					frac_r <= wdata;
				else
					fifo_en_r <= wdata[`FCR_EN];
			end
			`A_LCR: begin
				lcr_r <= wdata;
			end
			`A_MCR: begin
				mcr_r[4:0] <= wdata[4:0];
				if (feat_unlock)
					mcr_r[7:5] <= wdata[7:5];
			end
			`A_SHR: begin
				shr_r <= wdata;
			end
			default: begin
			end
			endcase
		end
		// RULE16: overrun sticks until the status is read.
		ovr_r <= ovr_ev | (ovr_r & ~lsr_rd);
		// RULE25: hysteresis band around the receive trigger.
		if (rx_cnt_r >= 8'h01 && {1'b0, rx_cnt_r} >= (prog_trig ? rts_hi : {1'b0, rx_trigger}))
			flow_off_r <= 1'b1;
		else if ({1'b0, rx_cnt_r} <= (prog_trig ? rts_lo : {1'b0, rx_trigger}) || rts_lo[8])
			flow_off_r <= ~prog_trig & (rx_cnt_r >= rx_trigger) & (rx_trigger != 8'h00);
		// RULE11: any character resumes a stopped transmitter.
		if (!sw_flow_en)
			tx_flow_stopped <= 1'b0;
		else if (rx_done && is_xoff)
			tx_flow_stopped <= 1'b1;
		else if (rx_done && !rx_brk && (is_xon || mcr_r[`MCR_XANY]))
			tx_flow_stopped <= 1'b0;
	end
end

// ==========================================
// Registered outputs
// ==========================================
// RULE15: data ready while the FIFO holds a character.
// RULE19: holding empty follows the transmit FIFO count.
// RULE20: transmitter empty needs FIFO and shifter empty.
wire [7:0] line_status = {err_cnt_r != 8'h00, (tx_cnt_r == 8'h00) & (tx_st_r != TS_SEND), tx_cnt_r == 8'h00,
	rx_any ? rx_head[10:8] : 3'h0, ovr_r, rx_any};

always @(posedge sys_clk) begin
	if (srst) begin
		rdata <= 8'h00;
		int_o <= 1'b0;
		int_oe <= 1'b0;
		tx_o <= 1'b1;
		dtr_n <= 1'b1;
		rts_n <= 1'b1;
		modem_pin_sel <= 1'b0;
		loop_out_one_n <= 1'b1;
		loop_out_two_n <= 1'b1;
	end else begin
		case (addr)
		`A_DATA: rdata <= dlab ? div_r[7:0] : rx_head[7:0];
		`A_IER: rdata <= dlab ? div_r[15:8] : ier_r;
		`A_FCR: rdata <= dlab ? frac_r : {fifo_en_r, fifo_en_r, 6'h01};
		`A_LCR: rdata <= lcr_r;
		`A_MCR: rdata <= mcr_r;
		`A_LSR: rdata <= line_status;
		default: rdata <= 8'h00;
		endcase
		// RULE14: overrun at once, tags once at the head.
		int_o <= ier_r[`IER_LINE] & (ovr_r | head_err);
		// RULE9: interrupt pin enable unless the bus mode ignores it.
		int_oe <= (bus_mode == `BUS_MODE_FIXED) | mcr_r[`MCR_INTEN];
		loop_out_two_n <= ~(loop & mcr_r[`MCR_INTEN]);
		// RULE8: pin select and loopback ring drive.
		modem_pin_sel <= mcr_r[`MCR_PINSEL];
		loop_out_one_n <= ~(loop & mcr_r[`MCR_PINSEL]);
		// RULE4: break holds the line low.
		if (lcr_r[`LCR_BRK])
			tx_o <= 1'b0;
		else if (loop)
			tx_o <= 1'b1;
		// RULE12: short high pulse per zero bit, low at idle.
		else if (mcr_r[`MCR_IR])
			tx_o <= ~tx_line & (tx_tick_r < `IR_PULSE);
		else
			tx_o <= tx_line;
		// RULE6: terminal ready pin is the inverse of its bit, held high in loopback.
		dtr_n <= loop | ~mcr_r[`MCR_DTR];
		// RULE7: send request pin, manual, flow or direction driven.
		if (loop)
			rts_n <= 1'b1;
		else if (half_duplex_en)
			rts_n <= (tx_st_r == TS_IDLE);
		else
			rts_n <= ~(mcr_r[`MCR_RTS] & ~(auto_rts_en & flow_off_r));
	end
end

endmodule

/* pkg/uart_lmsc_consts.vh */
// ==========================================
// Register offsets on the host port
// ==========================================
`ifndef UART_LMSC_CONSTS_VH
`define UART_LMSC_CONSTS_VH
`define A_DATA 3'h0
`define A_IER 3'h1
`define A_FCR 3'h2
`define A_LCR 3'h3
`define A_MCR 3'h4
`define A_LSR 3'h5
`define A_SHR 3'h6
// ==========================================
// Field positions
// ==========================================
`define LCR_PEN 3
`define LCR_EVEN 4
`define LCR_FORCE 5
`define LCR_BRK 6
`define LCR_DLAB 7
`define MCR_DTR 0
`define MCR_RTS 1
`define MCR_PINSEL 2
`define MCR_INTEN 3
`define MCR_LOOP 4
`define MCR_XANY 5
`define MCR_IR 6
`define MCR_PRESC 7
`define IER_LINE 2
`define FCR_EN 0
`define FCR_RXRST 1
`define FCR_TXRST 2
// ==========================================
// Reset values and timing counts
// ==========================================
`define LCR_RST 8'h00
`define MCR_RST 8'h00
`define IER_RST 8'h00
`define SHR_RST 8'h00
`define FRAC_RST 8'h00
`define DIV_RST 16'h0001
`define FIFO_DEPTH 8'h80
`define IR_PULSE 4'h3
`define IR_HOLD 5'h10
`define BUS_MODE_FIXED 2'h1
`endif

/* sim/uart_lmsc_assertions.sv */
`timescale 1ns/1ns
`include "uart_lmsc_consts.vh"
module uart_lmsc_checker (
	// Clock and reset
	input wire sys_clk,
	input wire srst,
	// Host port
	input wire [2:0] addr,
	input wire wr_stb,
	input wire [7:0] wdata,
	input wire [1:0] bus_mode,
	input wire feat_unlock,
	input wire half_duplex_en,
	input wire auto_rts_en,
	// Pins
	input wire tx_o,
	input wire dtr_n,
	input wire rts_n,
	input wire modem_pin_sel,
	input wire int_oe,
	input wire loop_out_one_n,
	input wire loop_out_two_n
);
// ==========================================
// Shadow of the control registers
// ==========================================
reg [7:0] lcr_r;
reg [7:0] mcr_r;
reg [1:0] age_r;
reg [8:0] quiet_r;
wire ok = age_r == 2'h2;
always @(posedge sys_clk) begin
	if (srst) begin
		lcr_r <= 8'h00;
		mcr_r <= 8'h00;
		age_r <= 2'h0;
		quiet_r <= 9'h000;
	end else begin
		if (wr_stb && addr == `A_LCR) begin
			lcr_r <= wdata;
		end
		if (wr_stb && addr == `A_MCR) begin
			mcr_r <= feat_unlock ? wdata : {mcr_r[7:5], wdata[4:0]};
		end
		age_r <= (wr_stb && (addr == `A_LCR || addr == `A_MCR)) ? 2'h0 : (ok ? age_r : age_r + 2'h1);
		quiet_r <= (wr_stb && addr == `A_DATA && !lcr_r[7]) ? 9'h000 : (&quiet_r ? quiet_r : quiet_r + 9'h001);
	end
end
wire idle = ok && &quiet_r && !mcr_r[4] && !mcr_r[7] && !lcr_r[6];
// ==========================================
// Properties
// ==========================================
default clocking cb @(posedge sys_clk); endclocking
default disable iff (srst);
a_dtr_level: assert property (ok && !mcr_r[4] |-> dtr_n == !mcr_r[0])
	else $error("dtr pin wrong");
a_rts_level: assert property (ok && !mcr_r[4] && !half_duplex_en && !auto_rts_en |-> rts_n == !mcr_r[1])
	else $error("rts pin wrong");
a_pin_select: assert property (ok |-> modem_pin_sel == mcr_r[2])
	else $error("pin select wrong");
a_loop_ring: assert property (ok |-> loop_out_one_n == !(mcr_r[4] && mcr_r[2]))
	else $error("loop ring output wrong");
a_loop_two: assert property (ok |-> loop_out_two_n == !(mcr_r[4] && mcr_r[3]))
	else $error("loop second output wrong");
a_int_enable: assert property (ok && !mcr_r[4] && bus_mode != `BUS_MODE_FIXED && $past(bus_mode) != `BUS_MODE_FIXED
	|-> int_oe == mcr_r[3])
	else $error("interrupt enable wrong");
a_break_low: assert property (ok && lcr_r[6] && !mcr_r[6] && !mcr_r[4] |-> (!tx_o || !lcr_r[6]) [*4])
	else $error("break not low");
a_ir_idle: assert property (idle && mcr_r[6] |-> !tx_o)
	else $error("infrared idle not low");
a_idle_mark: assert property (idle && !mcr_r[6] |-> tx_o)
	else $error("serial idle not high");
c_break: cover property (ok && lcr_r[6]);
c_loop: cover property (ok && mcr_r[4]);
c_ir: cover property (idle && mcr_r[6]);
endmodule
bind uart_lmsc uart_lmsc_checker u_chk (.sys_clk, .srst, .addr, .wr_stb, .wdata, .bus_mode, .feat_unlock,
	.half_duplex_en, .auto_rts_en, .tx_o, .dtr_n, .rts_n, .modem_pin_sel, .int_oe, .loop_out_one_n,
	.loop_out_two_n);

/* sim/uart_remote.sv */
`timescale 1ns/1ns
module uart_remote (
	// Clock
	input wire clk,
	// Serial line
	input wire line_in,
	output reg line_out
);
reg [8:0] got = 9'h000;
integer n_got = 0;
integer k;
integer r;
initial line_out = 1'b1;
// ==========================================
// Transmit side, sixteen cycles a bit
// ==========================================
task bit_out(input b);
	begin
		line_out = b;
		repeat (16) @(posedge clk);
		#1;
	end
endtask
task send(input [7:0] d, input pe, input pb, input sb);
	begin
		bit_out(1'b0);
		for (k = 0; k < 8; k = k + 1) begin
			bit_out(d[k]);
		end
		if (pe) begin
			bit_out(pb);
		end
		bit_out(sb);
		bit_out(1'b1);
	end
endtask
task brk(input integer n);
	begin
		repeat (n) bit_out(1'b0);
		bit_out(1'b1);
	end
endtask
// ==========================================
// Receive side, sampled at mid bit
// ==========================================
always begin
	@(negedge line_in);
	repeat (8) @(posedge clk);
	for (r = 0; r < 9; r = r + 1) begin
		repeat (16) @(posedge clk);
		got[r] = line_in;
	end
	n_got = n_got + 1;
end
endmodule

/* sim/uart_lmsc_tb_top.sv */
`timescale 1ns/1ns
`include "uart_lmsc_consts.vh"
module uart_lmsc_tb_top;
reg sys_clk = 1'b0;
reg srst = 1'b1;
reg [2:0] addr = 3'h0;
reg wr_stb = 1'b0;
reg rd_stb = 1'b0;
reg [7:0] wdata = 8'h00;
reg [1:0] bus_mode = 2'h0;
reg feat_unlock = 1'b1;
reg half_duplex_en = 1'b0;
reg auto_rts_en = 1'b0;
reg sw_flow_en = 1'b0;
wire [7:0] rdata;
wire int_o, int_oe, rx_i, tx_o, dtr_n, rts_n, modem_pin_sel, loop_out_one_n, loop_out_two_n, tx_flow_stopped;
integer fail_count = 0;
integer n_checks = 0;
integer cyc = 0;
integer i;
integer j;
reg [7:0] v;
reg [7:0] m;
always #5 sys_clk = ~sys_clk;
uart_lmsc DUT (.sys_clk, .srst, .addr, .wr_stb, .rd_stb, .wdata, .rdata, .bus_mode, .int_o, .int_oe, .rx_i,
	.tx_o, .dtr_n, .rts_n, .modem_pin_sel, .loop_out_one_n, .loop_out_two_n, .feat_unlock, .half_duplex_en,
	.auto_rts_en, .prog_trig(1'b0), .rx_trigger(8'h00), .sw_flow_en, .xon_char(8'h11),
	.xoff_char(8'h13), .tx_flow_stopped);
uart_remote PEER (.clk(sys_clk), .line_in(tx_o), .line_out(rx_i));
// ==========================================
// Access tasks
// ==========================================
task tick(input integer n);
	begin
		repeat (n) @(posedge sys_clk);
		#1;
	end
endtask
task chk(input [7:0] got, input [7:0] exp);
	begin
		n_checks = n_checks + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
endtask
task wr(input [2:0] a, input [7:0] d);
	begin
		@(posedge sys_clk) #1;
		addr = a;
		wdata = d;
		wr_stb = 1'b1;
		@(posedge sys_clk) #1;
		wr_stb = 1'b0;
	end
endtask
task rchk(input [2:0] a, input [7:0] exp);
	begin
		@(posedge sys_clk) #1;
		addr = a;
		rd_stb = 1'b1;
		@(posedge sys_clk) #1;
		rd_stb = 1'b0;
		chk(rdata, exp);
	end
endtask
task txwait;
	begin
		j = PEER.n_got;
		for (i = 0; i < 400 && PEER.n_got == j; i = i + 1) tick(1);
		#1;
	end
endtask
task stop_test;
	begin
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	end
endtask
always @(posedge sys_clk) begin
	cyc = cyc + 1;
	if (cyc == 20000) begin
		fail_count = fail_count + 1;
		stop_test;
	end
end
// ==========================================
// Tests
// ==========================================
initial begin
	tick(12);
	#1 srst = 1'b0;
	rchk(`A_LCR, 8'h00);
	rchk(`A_MCR, 8'h00);
	rchk(`A_LSR, 8'h60);
	wr(`A_FCR, 8'h01);
	wr(`A_LCR, 8'h80);
	wr(`A_DATA, 8'h01);
	wr(`A_IER, 8'h00);
	rchk(`A_DATA, 8'h01);
	rchk(`A_LSR, 8'h60);
	$display("reset and divisor test done");
	for (m = 0; m < 5; m = m + 1) begin
		v = (m == 0) ? 8'h03 : (8'h0B | ((m - 8'h01) << 4));
		wr(`A_LCR, v);
		wr(`A_DATA, 8'h34);
		txwait;
		chk(PEER.got[7:0], 8'h34);
		chk({7'h00, PEER.got[8]}, 8'h01 & (8'h0D >> m));
	end
	$display("transmit parity test done");
	wr(`A_LCR, 8'h1B);
	PEER.send(8'h34, 1'b1, 1'b0, 1'b1);
	rchk(`A_LSR, 8'hE5);
	rchk(`A_DATA, 8'h34);
	rchk(`A_LSR, 8'h60);
	wr(`A_LCR, 8'h2B);
	PEER.send(8'h35, 1'b1, 1'b0, 1'b1);
	rchk(`A_LSR, 8'hE5);
	rchk(`A_DATA, 8'h35);
	wr(`A_LCR, 8'h03);
	wr(`A_IER, 8'h04);
	chk({7'h00, int_o}, 8'h00);
	PEER.send(8'h5A, 1'b0, 1'b0, 1'b0);
	tick(2);
	chk({7'h00, int_o}, 8'h01);
	rchk(`A_LSR, 8'hE9);
	rchk(`A_DATA, 8'h5A);
	rchk(`A_LSR, 8'h60);
	wr(`A_IER, 8'h00);
	PEER.brk(12);
	rchk(`A_LSR, 8'hF1);
	rchk(`A_DATA, 8'h00);
	rchk(`A_LSR, 8'h60);
	$display("receive error test done");
	wr(`A_FCR, 8'h00);
	PEER.send(8'h11, 1'b0, 1'b0, 1'b1);
	PEER.send(8'h22, 1'b0, 1'b0, 1'b1);
	rchk(`A_LSR, 8'h63);
	rchk(`A_DATA, 8'h11);
	rchk(`A_LSR, 8'h60);
	wr(`A_FCR, 8'h01);
	$display("overrun test done");
	wr(`A_LCR, 8'h43);
	tick(40);
	chk({7'h00, tx_o}, 8'h00);
	wr(`A_LCR, 8'h03);
	tick(3);
	chk({7'h00, tx_o}, 8'h01);
	$display("break test done");
	for (m = 1; m < 16; m = m << 1) begin
		wr(`A_MCR, m);
		tick(3);
		chk({4'h0, dtr_n, rts_n, modem_pin_sel, int_oe}, {4'h0, ~m[0], ~m[1], m[2], m[3]});
	end
	wr(`A_MCR, 8'h00);
	bus_mode = `BUS_MODE_FIXED;
	tick(3);
	chk({7'h00, int_oe}, 8'h01);
	bus_mode = 2'h0;
	wr(`A_MCR, 8'h1C);
	tick(3);
	chk({5'h00, dtr_n, loop_out_one_n, loop_out_two_n}, 8'h04);
	wr(`A_DATA, 8'hA6);
	tick(250);
	rchk(`A_DATA, 8'hA6);
	wr(`A_MCR, 8'h80);
	rchk(`A_MCR, 8'h80);
	wr(`A_DATA, 8'hFF);
	tick(40);
	chk({7'h00, tx_o}, 8'h00);
	tick(640);
	wr(`A_MCR, 8'h00);
	$display("modem control test done");
	sw_flow_en = 1'b1;
	PEER.send(8'h13, 1'b0, 1'b0, 1'b1);
	chk({7'h00, tx_flow_stopped}, 8'h01);
	rchk(`A_LSR, 8'h60);
	wr(`A_MCR, 8'h22);
	auto_rts_en = 1'b1;
	PEER.send(8'h41, 1'b0, 1'b0, 1'b1);
	chk({7'h00, tx_flow_stopped}, 8'h00);
	chk({7'h00, rts_n}, 8'h01);
	rchk(`A_DATA, 8'h41);
	tick(2);
	chk({7'h00, rts_n}, 8'h00);
	auto_rts_en = 1'b0;
	sw_flow_en = 1'b0;
	wr(`A_MCR, 8'h00);
	$display("flow control test done");
	wr(`A_SHR, 8'h32);
	half_duplex_en = 1'b1;
	wr(`A_DATA, 8'h34);
	tick(30);
	chk({6'h00, tx_o, rts_n}, 8'h02);
	txwait;
	chk(PEER.got[7:0], 8'h34);
	tick(20);
	chk({7'h00, rts_n}, 8'h00);
	tick(40);
	chk({7'h00, rts_n}, 8'h01);
	half_duplex_en = 1'b0;
	wr(`A_MCR, 8'h40);
	tick(520);
	chk({7'h00, tx_o}, 8'h00);
	wr(`A_MCR, 8'h00);
	$display("direction and infrared test done");
	stop_test;
end
endmodule
